//--- logic/fsp_pkg.sv
package fsp_pkg;

  // Process data ranges: one each way, bytes at most
  localparam int unsigned MAX_BYTES = 76;
  localparam logic [9:0] MAX_BYTES_W = 10'h04c;
  // Byte index, station address and entry count widths
  localparam int unsigned IDX_W = 7;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned CNT_W = 7;
  // Highest usable station address
  localparam logic [6:0] ADDR_MAX = 7'h7e;

  // Buffer between host and input range
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // Lamp timing: one flash slot, ten slots make one cycle
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned FLASH_SLOT_MS = 100;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_SLOT_MS;
  localparam logic [3:0] PH_LAST = 4'h9;
  localparam logic [3:0] PH_FLASH1 = 4'h0;
  localparam logic [3:0] PH_FLASH2 = 4'h2;
  localparam logic [3:0] PH_HALF = 4'h5;

  // Element length code: bytes = 1 << code (1, 2, 4 or 8)
  typedef logic [1:0] fsp_len_t;

  // Bus mode as set by the master
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_CLEAR,
    MODE_OPERATE
  } fsp_mode_e;

  // Node state
  typedef enum logic [2:0] {
    NODE_UNINIT,
    NODE_WAIT,
    NODE_EXCH,
    NODE_MISMATCH,
    NODE_CFGERR
  } fsp_state_e;

  // Range size in bytes from entry count and length code
  function automatic logic [9:0] range_bytes(logic [6:0] cnt, fsp_len_t len);
    range_bytes = {3'h0, cnt} << len;
  endfunction

  // A range is legal when it holds entries and fits the limit
  function automatic logic range_ok(logic [6:0] cnt, fsp_len_t len);
    range_ok = (cnt != 7'h00) && (range_bytes(cnt, len) <= MAX_BYTES_W);
  endfunction

endpackage

//--- logic/fsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  // Whole state of the buffer
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } fsp_fifo_s;

  fsp_fifo_s q, d;
  logic push, pop;

  // Full and empty straight from the fill count
  assign in_ready = q.count != (AW + 1)'(DEPTH);
  assign out_valid = q.count != '0;
  assign out_data = q.mem[q.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: write, read, count
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wptr] = in_data;
      d.wptr = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
    end
    if (pop) begin
      d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
    end
    // Simultaneous push and pop leave the count alone
    if (push && !pop) begin
      d.count = q.count + 1'b1;
    end else if (pop && !push) begin
      d.count = q.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // fsp_fifo

`default_nettype wire

//--- logic/fsp_node.sv
// How it works
// - Stay uninitialized until host gives address, sizes
// - One input, one output range, 76 bytes max
// - Names follow master: output in, input out
// - One element length per direction: 1,2,4,8
// - One red flash on range mismatch
// - Run lamp: off, green, flash green, two red
// - Health lamp: off, green, flash green, red
// - Operate: exchange input and output ranges
// - Clear: inputs update, outputs forced zero
// - Stop: no bus participation at all
`timescale 1ns/1ps
`default_nettype none

module fsp_node #(
  parameter int unsigned FLASH_CYC_P = fsp_pkg::FLASH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host initialization
  input wire logic init_valid,
  input wire logic [6:0] init_addr,
  input wire logic [6:0] init_in_count,
  input wire fsp_pkg::fsp_len_t init_in_len,
  input wire logic [6:0] init_out_count,
  input wire fsp_pkg::fsp_len_t init_out_len,
  output logic init_done,
  output logic init_err,
  // Host input data stream, toward the master
  input wire logic host_in_valid,
  input wire logic [7:0] host_in_data,
  output logic host_in_ready,
  // Host output data reads, data from the master
  input wire logic host_out_req,
  input wire logic [6:0] host_out_idx,
  output logic host_out_valid,
  output logic [7:0] host_out_data,
  // Host status events
  input wire logic diag_event,
  input wire logic diag_clear,
  input wire logic exception_err,
  // Master link
  input wire logic [6:0] bus_addr,
  input wire fsp_pkg::fsp_mode_e bus_mode,
  input wire logic bus_cfg_valid,
  input wire logic [6:0] bus_cfg_out_count,
  input wire fsp_pkg::fsp_len_t bus_cfg_out_len,
  input wire logic [6:0] bus_cfg_in_count,
  input wire fsp_pkg::fsp_len_t bus_cfg_in_len,
  input wire logic bus_wr_valid,
  input wire logic [6:0] bus_wr_idx,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_rd_req,
  input wire logic [6:0] bus_rd_idx,
  output logic bus_rd_valid,
  output logic [7:0] bus_rd_data,
  // Status lamps
  output logic run_lamp_green,
  output logic run_lamp_red,
  output logic health_lamp_green,
  output logic health_lamp_red
);

  // Whole state of the node
  typedef struct packed {
    fsp_pkg::fsp_state_e state;            // Node state
    logic [6:0] addr;                      // Station address
    logic [6:0] in_count;                  // Input range entries
    fsp_pkg::fsp_len_t in_len;             // Input element length
    logic [6:0] out_count;                 // Output range entries
    fsp_pkg::fsp_len_t out_len;            // Output element length
    logic [6:0] in_wptr;                   // Next input byte from host
    logic diag;                            // Diagnostic event pending
    logic init_err;                        // Refused init pulse
    logic rd_valid;                        // Answer to master read
    logic [7:0] rd_data;
    logic hout_valid;                      // Answer to host read
    logic [7:0] hout_data;
    logic [31:0] tick_cnt;                 // Flash slot divider
    logic [3:0] phase;                     // Slot within flash cycle
    logic run_g, run_r, hl_g, hl_r;        // Lamp drivers
    logic [fsp_pkg::MAX_BYTES-1:0][7:0] in_mem;  // Toward master
    logic [fsp_pkg::MAX_BYTES-1:0][7:0] out_mem; // From master
  } fsp_node_s;

  fsp_node_s q, d;

  // Buffer between host stream and input range
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_ready;
  logic fifo_in_ready;

  // Decodes shared by the next-state logic
  logic inited, hit, exch, bus_rd_hit;
  logic [9:0] in_bytes, out_bytes;

  fsp_fifo #(
    .WIDTH(fsp_pkg::FIFO_WIDTH),
    .DEPTH(fsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(host_in_valid && inited),
    .in_data(host_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_ready)
  );

  assign inited = q.state != fsp_pkg::NODE_UNINIT;
  assign hit = inited && (bus_addr == q.addr);
  assign exch = hit && (q.state == fsp_pkg::NODE_EXCH) &&
                (bus_mode != fsp_pkg::MODE_STOP);
  assign in_bytes = fsp_pkg::range_bytes(q.in_count, q.in_len);
  assign out_bytes = fsp_pkg::range_bytes(q.out_count, q.out_len);
  assign bus_rd_hit = exch && bus_rd_req;
  // Host stream held off until initialized
  assign host_in_ready = fifo_in_ready && inited;
  // Master reads take the input range port first, the host waits
  assign fifo_ready = inited && !bus_rd_hit;

  assign init_done = inited;
  assign init_err = q.init_err;
  assign host_out_valid = q.hout_valid;
  assign host_out_data = q.hout_data;
  assign bus_rd_valid = q.rd_valid;
  assign bus_rd_data = q.rd_data;
  assign run_lamp_green = q.run_g;
  assign run_lamp_red = q.run_r;
  assign health_lamp_green = q.hl_g;
  assign health_lamp_red = q.hl_r;

  // Next state of the whole node
  always_comb begin
    d = q;
    d.init_err = 1'b0;
    d.rd_valid = 1'b0;
    d.hout_valid = 1'b0;

    // Flash slot divider and cycle phase
    if (q.tick_cnt >= FLASH_CYC_P - 1) begin
      d.tick_cnt = '0;
      d.phase = (q.phase == fsp_pkg::PH_LAST) ? '0 : q.phase + 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 1'b1;
    end

    // Host initialization, taken once only
    if (init_valid && !inited) begin
      if (init_addr <= fsp_pkg::ADDR_MAX &&
          fsp_pkg::range_ok(init_in_count, init_in_len) &&
          fsp_pkg::range_ok(init_out_count, init_out_len)) begin
        d.state = fsp_pkg::NODE_WAIT;
        d.addr = init_addr;
        d.in_count = init_in_count;
        d.in_len = init_in_len;
        d.out_count = init_out_count;
        d.out_len = init_out_len;
        d.in_wptr = '0;
      end else begin
        d.init_err = 1'b1;
      end
    end

    // Master configuration check, addressed to us only
    if (inited && bus_mode == fsp_pkg::MODE_STOP) begin
      d.state = fsp_pkg::NODE_WAIT;
    end else if (hit && bus_cfg_valid) begin
      if (!fsp_pkg::range_ok(bus_cfg_out_count, bus_cfg_out_len) ||
          !fsp_pkg::range_ok(bus_cfg_in_count, bus_cfg_in_len)) begin
        d.state = fsp_pkg::NODE_CFGERR;
      end else if (bus_cfg_out_count != q.out_count ||
                   bus_cfg_out_len != q.out_len ||
                   bus_cfg_in_count != q.in_count ||
                   bus_cfg_in_len != q.in_len) begin
        // Master output pairs with our output range
        d.state = fsp_pkg::NODE_MISMATCH;
      end else begin
        d.state = fsp_pkg::NODE_EXCH;
      end
    end

    // Data from the master: stored in operate, zeroed in clear
    if (exch && bus_mode == fsp_pkg::MODE_CLEAR) begin
      d.out_mem = '0;
    end else if (exch && bus_wr_valid && {3'h0, bus_wr_idx} < out_bytes) begin
      d.out_mem[bus_wr_idx] = bus_wr_data;
    end

    // Master reads of the input range, in operate and clear
    if (bus_rd_hit && {3'h0, bus_rd_idx} < in_bytes) begin
      d.rd_valid = 1'b1;
      d.rd_data = q.in_mem[bus_rd_idx];
    end

    // Host bytes fill the input range in order, then wrap
    if (fifo_valid && fifo_ready) begin
      d.in_mem[q.in_wptr] = fifo_data;
      if ({3'h0, q.in_wptr} >= in_bytes - 10'h001) begin
        d.in_wptr = '0;
      end else begin
        d.in_wptr = q.in_wptr + 1'b1;
      end
    end

    // Host reads of the output range
    if (host_out_req && inited && {3'h0, host_out_idx} < out_bytes) begin
      d.hout_valid = 1'b1;
      d.hout_data = q.out_mem[host_out_idx];
    end

    // Diagnostic flag, a new event beats the clear
    d.diag = inited && (diag_event || (q.diag && !diag_clear));

    // Run-state lamp
    d.run_g = 1'b0;
    d.run_r = 1'b0;
    case (q.state)
      fsp_pkg::NODE_EXCH: begin
        if (bus_mode == fsp_pkg::MODE_OPERATE) begin
          d.run_g = 1'b1;
        end else if (bus_mode == fsp_pkg::MODE_CLEAR) begin
          d.run_g = q.phase < fsp_pkg::PH_HALF;
        end
      end
      fsp_pkg::NODE_MISMATCH: begin
        d.run_r = q.phase == fsp_pkg::PH_FLASH1;
      end
      fsp_pkg::NODE_CFGERR: begin
        d.run_r = q.phase == fsp_pkg::PH_FLASH1 ||
                  q.phase == fsp_pkg::PH_FLASH2;
      end
      default: begin
        // Offline: lamp dark
        d.run_g = 1'b0;
      end
    endcase

    // Health lamp
    d.hl_g = 1'b0;
    d.hl_r = 1'b0;
    if (exception_err) begin
      d.hl_r = 1'b1;
    end else if (inited && q.diag) begin
      d.hl_g = q.phase < fsp_pkg::PH_HALF;
    end else if (inited) begin
      d.hl_g = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // fsp_node

`default_nettype wire

//--- tb/fsp_checker.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host side
  input wire logic init_done,
  input wire logic host_in_ready,
  input wire logic host_out_req,
  input wire logic host_out_valid,
  input wire logic [7:0] host_out_data,
  input wire logic exception_err,
  // Master side
  input wire fsp_pkg::fsp_mode_e bus_mode,
  input wire logic bus_rd_req,
  input wire logic bus_rd_valid,
  // Lamps
  input wire logic run_lamp_green,
  input wire logic run_lamp_red,
  input wire logic health_lamp_green,
  input wire logic health_lamp_red
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Init stays until reset
  property p_hold;
    init_done |=> init_done;
  endproperty
  a_hold: assert property (p_hold) else $error("init lost");
  // No stream bytes before init
  property p_rdy;
    !init_done |-> !host_in_ready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready early");
  // Host answers only after an initialized request
  property p_hov;
    host_out_valid |-> $past(host_out_req && init_done);
  endproperty
  a_hov: assert property (p_hov) else $error("stray answer");
  // No master answer in stop mode
  property p_rd;
    bus_rd_valid |-> $past(bus_rd_req) && $past(bus_mode) != fsp_pkg::MODE_STOP;
  endproperty
  a_rd: assert property (p_rd) else $error("read in stop");
  // Clear mode reads back zero
  property p_clr;
    host_out_valid && $past(bus_mode) == fsp_pkg::MODE_CLEAR
      && $past(bus_mode, 2) == fsp_pkg::MODE_CLEAR |-> host_out_data == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("clear not zero");
  // Stop turns the run lamp off
  property p_stop;
    bus_mode == fsp_pkg::MODE_STOP [*2] |=> !run_lamp_green && !run_lamp_red;
  endproperty
  a_stop: assert property (p_stop) else $error("lamp in stop");
  // Exception lights health red
  property p_exc;
    $rose(exception_err) |-> ##[1:2] health_lamp_red;
  endproperty
  a_exc: assert property (p_exc) else $error("no red");
  // Uninitialized node shows no green
  property p_off;
    !init_done |=> !health_lamp_green && !run_lamp_green;
  endproperty
  a_off: assert property (p_off) else $error("green early");
  // Run lamp never both colours
  property p_mix;
    !(run_lamp_green && run_lamp_red);
  endproperty
  a_mix: assert property (p_mix) else $error("lamp mixed");

  // Main scenarios reached
  c_init: cover property ($rose(init_done));
  c_rd: cover property (bus_rd_valid);
  c_clr: cover property (host_out_valid && bus_mode == fsp_pkg::MODE_CLEAR);
endmodule // fsp_checker

`default_nettype wire

//--- tb/fsp_master.sv
`timescale 1ns/1ps
`default_nettype none

module fsp_master (
  // Clock
  input wire logic clk,
  // Requests toward the node
  output logic [6:0] bus_addr,
  output fsp_pkg::fsp_mode_e bus_mode,
  output logic bus_cfg_valid,
  output logic [6:0] bus_cfg_out_count,
  output fsp_pkg::fsp_len_t bus_cfg_out_len,
  output logic [6:0] bus_cfg_in_count,
  output fsp_pkg::fsp_len_t bus_cfg_in_len,
  output logic bus_wr_valid,
  output logic [6:0] bus_wr_idx,
  output logic [7:0] bus_wr_data,
  output logic bus_rd_req,
  output logic [6:0] bus_rd_idx,
  // Answers
  input wire logic bus_rd_valid,
  input wire logic [7:0] bus_rd_data
);
  // Idle bus, stopped
  initial begin
    {bus_addr, bus_cfg_valid, bus_wr_valid, bus_rd_req} = '0;
    {bus_cfg_out_count, bus_cfg_out_len} = '0;
    {bus_cfg_in_count, bus_cfg_in_len} = '0;
    {bus_wr_idx, bus_wr_data, bus_rd_idx} = '0;
    bus_mode = fsp_pkg::MODE_STOP;
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic mode(input fsp_pkg::fsp_mode_e m);
    bus_mode = m;
  endtask

  // Declares outputs first, then inputs
  task automatic cfg(input logic [6:0] a, oc, input fsp_pkg::fsp_len_t ol,
                     input logic [6:0] ic, input fsp_pkg::fsp_len_t il);
    bus_addr = a;
    {bus_cfg_out_count, bus_cfg_out_len} = {oc, ol};
    {bus_cfg_in_count, bus_cfg_in_len} = {ic, il};
    bus_cfg_valid = 1'b1;
    step;
    bus_cfg_valid = 1'b0;
  endtask

  // One output byte; data line toggles once released
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    {bus_wr_idx, bus_wr_data, bus_wr_valid} = {i, d, 1'b1};
    step;
    bus_wr_valid = 1'b0;
    bus_wr_data = ~d;
    // Idle edge so a following write never re-raises valid at once
    step;
  endtask

  // One input byte read
  task automatic rd(input logic [6:0] i, output logic v, output logic [7:0] d);
    {bus_rd_idx, bus_rd_req} = {i, 1'b1};
    step;
    bus_rd_req = 1'b0;
    v = bus_rd_valid;
    d = bus_rd_data;
    // Idle edge between reads
    step;
  endtask

  // Back to back reads that stall the host buffer
  task automatic hold(input int n);
    {bus_rd_idx, bus_rd_req} = {7'h00, 1'b1};
    repeat (n) step;
    bus_rd_req = 1'b0;
  endtask
endmodule // fsp_master

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end

module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  int num_errors = 0;
  int num_checks = 0;
  // Host side drive
  logic iv = 0, hv = 0, hr = 0, de = 0, dc = 0, ex = 0;
  logic [6:0] ia = 0, ic = 0, oc = 0, hx = 0;
  fsp_pkg::fsp_len_t il = 0, ol = 0;
  logic [7:0] hd = 0;
  // Node outputs
  logic done, err, hrdy, hov, rv, rg, rr, hg, hred;
  logic [7:0] hod, rd;
  // Master lines
  logic [6:0] ba, coc, cic, wi, ri;
  fsp_pkg::fsp_mode_e bm;
  fsp_pkg::fsp_len_t col, cil;
  logic cv, wv, rq;
  logic [7:0] wd;
  logic [3:0] lamps;
  assign lamps = {rg, rr, hg, hred};

  // 25 MHz
  always #20 clk = ~clk;

  fsp_node #(.FLASH_CYC_P(4)) uut (.clk(clk), .resetn(resetn),
    .init_valid(iv), .init_addr(ia), .init_in_count(ic), .init_in_len(il),
    .init_out_count(oc), .init_out_len(ol), .init_done(done), .init_err(err),
    .host_in_valid(hv), .host_in_data(hd), .host_in_ready(hrdy),
    .host_out_req(hr), .host_out_idx(hx), .host_out_valid(hov),
    .host_out_data(hod), .diag_event(de), .diag_clear(dc),
    .exception_err(ex), .bus_addr(ba), .bus_mode(bm), .bus_cfg_valid(cv),
    .bus_cfg_out_count(coc), .bus_cfg_out_len(col), .bus_cfg_in_count(cic),
    .bus_cfg_in_len(cil), .bus_wr_valid(wv), .bus_wr_idx(wi),
    .bus_wr_data(wd), .bus_rd_req(rq), .bus_rd_idx(ri), .bus_rd_valid(rv),
    .bus_rd_data(rd), .run_lamp_green(rg), .run_lamp_red(rr),
    .health_lamp_green(hg), .health_lamp_red(hred));

  fsp_master m (.clk(clk), .bus_addr(ba), .bus_mode(bm), .bus_cfg_valid(cv),
    .bus_cfg_out_count(coc), .bus_cfg_out_len(col), .bus_cfg_in_count(cic),
    .bus_cfg_in_len(cil), .bus_wr_valid(wv), .bus_wr_idx(wi),
    .bus_wr_data(wd), .bus_rd_req(rq), .bus_rd_idx(ri), .bus_rd_valid(rv),
    .bus_rd_data(rd));

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  // Init request, answer one cycle later
  task automatic init(input logic [6:0] a, c1, input fsp_pkg::fsp_len_t l1,
                      input logic [6:0] c2, input fsp_pkg::fsp_len_t l2,
                      input logic e);
    {ia, ic, il, oc, ol, iv} = {a, c1, l1, c2, l2, 1'b1};
    step;
    iv = 1'b0;
    `CHK(err, e)
    `CHK(done, !e)
    // Idle edge so a following request is a fresh pulse
    step;
  endtask

  // Host read of the output range
  task automatic hrd(input logic [6:0] i, input logic v, input logic [7:0] d);
    {hx, hr} = {i, 1'b1};
    step;
    hr = 1'b0;
    `CHK(hov, v)
    if (v) `CHK(hod, d)
    // Idle edge between host reads
    step;
  endtask

  // Master read of the input range
  task automatic brd(input logic [6:0] i, input logic v, input logic [7:0] d);
    logic gv;
    logic [7:0] gd;
    m.rd(i, gv, gd);
    `CHK(gv, v)
    if (v) `CHK(gd, d)
  endtask

  // Lit cycles of one lamp over a full flash cycle
  task automatic lamp(input int s, input int e);
    int n;
    n = 0;
    repeat (2) step;
    repeat (40) begin
      step;
      n += lamps[s];
    end
    `CHK(n, e)
  endtask

  task automatic t_init;
    `CHK(hrdy, 1'b0)
    hrd(7'h00, 1'b0, 8'h00);
    init(7'h7f, 7'h01, 2'h0, 7'h01, 2'h0, 1'b1);
    init(7'h05, 7'h13, 2'h2, 7'h4d, 2'h0, 1'b1);
    init(7'h05, 7'h04, 2'h1, 7'h4c, 2'h0, 1'b0);
    `CHK(hrdy, 1'b1)
    lamp(1, 40);
  endtask

  task automatic t_cfg;
    m.mode(fsp_pkg::MODE_OPERATE);
    m.cfg(7'h05, 7'h4b, 2'h0, 7'h04, 2'h1);
    lamp(2, 4);
    m.mode(fsp_pkg::MODE_STOP);
    step;
    m.mode(fsp_pkg::MODE_OPERATE);
    m.cfg(7'h05, 7'h4c, 2'h0, 7'h00, 2'h1);
    lamp(2, 8);
    m.mode(fsp_pkg::MODE_STOP);
    step;
    m.mode(fsp_pkg::MODE_OPERATE);
    m.cfg(7'h06, 7'h4c, 2'h0, 7'h04, 2'h1);
    lamp(3, 0);
    m.cfg(7'h05, 7'h4c, 2'h0, 7'h04, 2'h1);
    lamp(3, 40);
  endtask

  task automatic t_data;
    m.wr(7'h00, 8'h11);
    m.wr(7'h4b, 8'h22);
    hrd(7'h00, 1'b1, 8'h11);
    hrd(7'h4b, 1'b1, 8'h22);
    hrd(7'h4c, 1'b0, 8'h00);
    hv = 1'b1;
    for (int i = 0; i < 8; i++) begin
      hd = 8'ha0 + 8'(i);
      step;
    end
    hv = 1'b0;
    repeat (4) step;
    for (int i = 0; i < 8; i++) brd(7'(i), 1'b1, 8'ha0 + 8'(i));
    brd(7'h08, 1'b0, 8'h00);
  endtask

  // Master reads stall the buffer until it refuses
  task automatic t_fill;
    int n;
    logic ok;
    n = 0;
    fork
      m.hold(26);
      begin
        repeat (2) step;
        hv = 1'b1;
        for (int i = 0; i < 20; i++) begin
          ok = hrdy;
          hd = 8'(i);
          step;
          n += ok;
        end
        hv = 1'b0;
      end
    join
    `CHK(n, 16)
    repeat (20) step;
    `CHK(hrdy, 1'b1)
    brd(7'h03, 1'b1, 8'h0b);
  endtask

  task automatic t_clear;
    m.mode(fsp_pkg::MODE_CLEAR);
    repeat (2) step;
    hrd(7'h00, 1'b1, 8'h00);
    m.wr(7'h01, 8'h33);
    hrd(7'h01, 1'b1, 8'h00);
    brd(7'h03, 1'b1, 8'h0b);
    lamp(3, 20);
  endtask

  task automatic t_health;
    de = 1'b1;
    step;
    de = 1'b0;
    lamp(1, 20);
    dc = 1'b1;
    step;
    dc = 1'b0;
    lamp(1, 40);
    ex = 1'b1;
    lamp(0, 40);
    ex = 1'b0;
  endtask

  task automatic t_stop;
    m.mode(fsp_pkg::MODE_STOP);
    step;
    brd(7'h00, 1'b0, 8'h00);
    lamp(3, 0);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_init;
    t_cfg;
    t_data;
    t_fill;
    t_clear;
    t_health;
    t_stop;
    close_out;
  end

  // Hang guard
  initial begin
    #1_000_000;
    num_errors++;
    close_out;
  end
endmodule // testbench

bind fsp_node fsp_checker chk (.clk(clk), .resetn(resetn),
  .init_done(init_done), .host_in_ready(host_in_ready),
  .host_out_req(host_out_req), .host_out_valid(host_out_valid),
  .host_out_data(host_out_data), .exception_err(exception_err),
  .bus_mode(bus_mode), .bus_rd_req(bus_rd_req), .bus_rd_valid(bus_rd_valid),
  .run_lamp_green(run_lamp_green), .run_lamp_red(run_lamp_red),
  .health_lamp_green(health_lamp_green), .health_lamp_red(health_lamp_red));

`default_nettype wire
